/* File: core/adc_out_core.v */
// Top of the ADC output interface: AHB-Lite registers, clock select,
// power-down, reference settle timing and interrupt.
// Assumes all pins synchronous to hclk and a single AHB-Lite master.
//
// Behaviour
// RQ1: Out-of-range flag high when input exceeds full scale, low within it.
// RQ2: Each result is a 12-bit parallel word, bit 11 most significant.
// RQ3: Data-valid clock comes from the conversion clock with corrected duty cycle.
// RQ4: Back-end logic may latch word and flag on the data-valid clock.
// RQ5: Power-down high stops conversion; low means normal operation.
// RQ6: Format select low gives two's complement output words.
// RQ7: Format select high gives Gray coded output words.
// RQ8: Clock type select low means single-ended clock, high means differential.
// RQ9: Equalizer enable low bypasses the duty-cycle equalizer, high uses it.
// RQ10: Output word appears 8.5 conversion clock cycles after its sample.
// RQ11: Samples are taken on the conversion clock falling edge.
// RQ12: After power-down release or power-up, allow 10 ms reference settling.
// RQ13: Gray output is reflected Gray code of the offset-binary value.
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_defs.vh"

module adc_out_core #(
    parameter SETTLE_CYCLES = `REF_SETTLE_NS / `HCLK_PERIOD_NS
) (
    input  wire                         hclk,
    input  wire                         hresetn,
    input  wire                         hsel,
    input  wire [31:0]                  haddr,
    input  wire [1:0]                   htrans,
    input  wire                         hwrite,
    input  wire [2:0]                   hsize,
    input  wire [31:0]                  hwdata,
    input  wire                         hready,
    output reg  [31:0]                  hrdata,
    output reg                          hreadyout,
    output reg                          hresp,
    input  wire                         conv_clk_p,
    input  wire                         conv_clk_n,
    input  wire signed [`ANALOG_W-1:0]  analog_sample,
    input  wire                         power_down_input,
    output reg  [`WORD_W-1:0]           sample_word_bus,
    output reg                          out_of_range_flag,
    output reg                          data_valid_clock,
    output reg                          irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [`CTRL_W-1:0]      ctrl_r;
    reg  [`EVT_W-1:0]       status_r;
    reg  [`EVT_W-1:0]       status_nxt;
    reg  [`EVT_W-1:0]       mask_r;
    reg                     wr_pend_r;
    reg  [`ADDR_W-1:0]      wr_addr_r;
    reg  [`SETTLE_W-1:0]    settle_cnt_r;
    reg                     settled_r;
    reg  [31:0]             rd_nxt;
    reg                     conv_clk_sel;
    wire                    halted;
    wire                    addr_ok;
    wire [`ADDR_W-1:0]      addr_lo;
    wire                    rise_evt;
    wire                    fall_evt;
    wire                    dv_clk;
    wire [`PER_W-1:0]       period;
    wire [`WORD_W-1:0]      word_w;
    wire                    oor_w;
    wire                    word_evt;
    wire                    settle_evt;
    wire [`EVT_W-1:0]       evt_vec;

    localparam [31:0]          SETTLE_M1   = SETTLE_CYCLES - 1;
    localparam [`SETTLE_W-1:0] SETTLE_LAST = SETTLE_M1[`SETTLE_W-1:0];

    // Power-down from the pin or from software; either one stops the path.
    assign halted  = power_down_input | ctrl_r[`CTRL_OFF]; // RQ5
    assign addr_lo = haddr[`ADDR_W-1:0];
    assign addr_ok = hsel & hready & (htrans == `HTRANS_NONSEQ);

    // ****************************************************************
    // Clock input type
    // ****************************************************************
    always @* begin
        if (ctrl_r[`CTRL_DIFF]) begin
            conv_clk_sel = conv_clk_p & ~conv_clk_n; // RQ8
        end else begin
            conv_clk_sel = conv_clk_p; // RQ8
        end
    end

    duty_equalizer u_equ (
        .clk      (hclk),
        .rst_n    (hresetn),
        .conv_clk (conv_clk_sel),
        .equ_en   (ctrl_r[`CTRL_EQU]),
        .halt     (halted),
        .rise_evt (rise_evt),
        .fall_evt (fall_evt),
        .dv_clk   (dv_clk),
        .period   (period)
    );

    sample_pipe u_pipe (
        .clk       (hclk),
        .rst_n     (hresetn),
        .flush     (halted),
        .take      (fall_evt),
        .shift     (rise_evt),
        .gray_sel  (ctrl_r[`CTRL_GRAY]),
        .analog_in (analog_sample),
        .word_out  (word_w),
        .oor_out   (oor_w),
        .word_evt  (word_evt)
    );

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_word_bus   <= {`WORD_W{1'b0}};
            out_of_range_flag <= 1'b0;
            data_valid_clock  <= 1'b0;
        end else begin
            // Word and flag change together so a latch on the valid clock
            // sees a consistent pair.
            sample_word_bus   <= word_w; // RQ2
            out_of_range_flag <= oor_w;  // RQ1
            data_valid_clock  <= dv_clk; // RQ3 RQ4
        end
    end

    // ****************************************************************
    // Reference settle timer
    // ****************************************************************
    // Restarts at reset and on every power-down release; results before
    // the settled flag rises should not be trusted.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_cnt_r <= {`SETTLE_W{1'b0}};
            settled_r    <= 1'b0;
        end else begin
            if (halted) begin
                settle_cnt_r <= {`SETTLE_W{1'b0}};
                settled_r    <= 1'b0;
            end else if (!settled_r) begin
                if (settle_cnt_r == SETTLE_LAST) begin
                    settled_r <= 1'b1; // RQ12
                end else begin
                    settle_cnt_r <= settle_cnt_r + {{(`SETTLE_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign settle_evt = ~halted & ~settled_r & (settle_cnt_r == SETTLE_LAST);

    assign evt_vec = {settle_evt, word_evt & oor_w, word_evt};

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    // Zero wait states: read data is formed in the address phase and
    // registered, so it stands through the whole data phase.
    always @* begin
        rd_nxt = `DATA_ZERO;
        case (addr_lo)
            `ADDR_CTRL: begin
                rd_nxt[`CTRL_W-1:0] = ctrl_r;
            end
            `ADDR_STATUS: begin
                rd_nxt[`EVT_W-1:0] = status_r;
            end
            `ADDR_MASK: begin
                rd_nxt[`EVT_W-1:0] = mask_r;
            end
            `ADDR_SAMPLE: begin
                rd_nxt[`WORD_W-1:0]  = sample_word_bus;
                rd_nxt[`SMP_OOR]     = out_of_range_flag;
                rd_nxt[`SMP_SETTLED] = settled_r;
            end
            `ADDR_PERIOD: begin
                rd_nxt[`PER_W-1:0] = period;
            end
            default: begin
                rd_nxt = `DATA_ZERO;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= `DATA_ZERO;
            hreadyout <= 1'b1;
            hresp     <= `HRESP_OKAY;
            wr_pend_r <= 1'b0;
            wr_addr_r <= {`ADDR_W{1'b0}};
        end else begin
            hreadyout <= 1'b1;
            hresp     <= `HRESP_OKAY;
            wr_pend_r <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_r <= addr_lo;
            end
            if (addr_ok & ~hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // ****************************************************************
    // Control, status and mask registers
    // ****************************************************************
    always @* begin
        status_nxt = status_r;
        if (wr_pend_r && (wr_addr_r == `ADDR_STATUS)) begin
            status_nxt = status_r & ~hwdata[`EVT_W-1:0];
        end
        // A new event wins over a clear in the same cycle.
        status_nxt = status_nxt | evt_vec;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r   <= `CTRL_RST;
            mask_r   <= `EVT_RST;
            status_r <= `EVT_RST;
            irq      <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq      <= |(status_nxt & mask_r);
            if (wr_pend_r && (wr_addr_r == `ADDR_CTRL)) begin
                ctrl_r <= hwdata[`CTRL_W-1:0]; // RQ5 RQ6 RQ7 RQ8 RQ9
            end
            if (wr_pend_r && (wr_addr_r == `ADDR_MASK)) begin
                mask_r <= hwdata[`EVT_W-1:0];
            end
        end
    end

endmodule
`default_nettype wire

/* File: core/adc_out_defs.vh */
// Constants for the ADC output interface: register map, fields, timing.
// Assumes inclusion by every design file of the block; holds no logic.
`ifndef ADC_OUT_DEFS_VH
`define ADC_OUT_DEFS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_W          8
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_MASK       8'h08
`define ADDR_SAMPLE     8'h0C
`define ADDR_PERIOD     8'h10

// ****************************************************************
// Fields
// ****************************************************************
`define CTRL_W          4
`define CTRL_GRAY       0
`define CTRL_DIFF       1
`define CTRL_EQU        2
`define CTRL_OFF        3
`define CTRL_RST        4'h4
`define EVT_W           3
`define EVT_WORD        0
`define EVT_OOR         1
`define EVT_SETTLED     2
`define EVT_RST         3'h0
`define SMP_OOR         12
`define SMP_SETTLED     13

// ****************************************************************
// Data path
// ****************************************************************
`define WORD_W          12
`define WORD_MSB        11
`define ANALOG_W        14
`define FS_POS          14'sh07FF
`define FS_NEG          -14'sh0800
`define CLIP_POS        12'h7FF
`define CLIP_NEG        12'h800
`define PIPE_DEPTH      8
`define PER_W           16
`define PER_ONE         16'h0001
`define PER_MAX         16'hFFFF

// ****************************************************************
// Timing
// ****************************************************************
`define HCLK_PERIOD_NS  4
`define REF_SETTLE_NS   10000000
`define SETTLE_W        22

// ****************************************************************
// Bus
// ****************************************************************
`define HTRANS_NONSEQ   2'h2
`define HRESP_OKAY      1'h0
`define DATA_ZERO       32'h0000_0000

`endif

/* File: core/duty_equalizer.v */
// Duty-cycle equalizer: rebuilds the conversion clock with a 50% duty.
// Assumes the selected conversion clock level is synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_defs.vh"

module duty_equalizer (
    input  wire                 clk,
    input  wire                 rst_n,
    input  wire                 conv_clk,
    input  wire                 equ_en,
    input  wire                 halt,
    output reg                  rise_evt,
    output reg                  fall_evt,
    output reg                  dv_clk,
    output reg  [`PER_W-1:0]    period
);

    reg                 conv_d_r;
    reg [`PER_W-1:0]    cnt_r;
    reg [`PER_W-1:0]    high_left_r;

    // ****************************************************************
    // Edge detection and period measurement
    // ****************************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_d_r    <= 1'b0;
            cnt_r       <= `PER_ONE;
            period      <= {`PER_W{1'b0}};
            rise_evt    <= 1'b0;
            fall_evt    <= 1'b0;
            dv_clk      <= 1'b0;
            high_left_r <= {`PER_W{1'b0}};
        end else if (halt) begin
            conv_d_r    <= conv_clk;
            cnt_r       <= `PER_ONE;
            rise_evt    <= 1'b0;
            fall_evt    <= 1'b0;
            dv_clk      <= 1'b0;
            high_left_r <= {`PER_W{1'b0}};
        end else begin
            conv_d_r <= conv_clk;
            rise_evt <= conv_clk & ~conv_d_r;
            fall_evt <= ~conv_clk & conv_d_r;
            if (conv_clk & ~conv_d_r) begin
                period <= cnt_r;
                cnt_r  <= `PER_ONE;
            end else if (cnt_r != `PER_MAX) begin
                cnt_r <= cnt_r + `PER_ONE;
            end
            // The high time is half the last measured period, so the input
            // duty cycle no longer shows; the first period after power-up
            // has no measure yet and keeps the output low.
            if (!equ_en) begin
                dv_clk <= conv_clk; // RQ9
            end else if (conv_clk & ~conv_d_r) begin
                dv_clk      <= (period > `PER_ONE);                  // RQ3
                high_left_r <= (period >> 1) - `PER_ONE;            // RQ3
            end else if (high_left_r != {`PER_W{1'b0}}) begin
                high_left_r <= high_left_r - `PER_ONE;
            end else begin
                dv_clk <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* File: core/sample_pipe.v */
// Conversion pipeline: samples on falling edges, delivers on rising edges.
// Assumes take and shift are one-cycle pulses from the equalizer.
`timescale 1ns/10ps
`default_nettype none
`include "adc_out_defs.vh"

module sample_pipe (
    input  wire                         clk,
    input  wire                         rst_n,
    input  wire                         flush,
    input  wire                         take,
    input  wire                         shift,
    input  wire                         gray_sel,
    input  wire signed [`ANALOG_W-1:0]  analog_in,
    output reg         [`WORD_W-1:0]    word_out,
    output reg                          oor_out,
    output reg                          word_evt
);

    reg [`WORD_W:0]    hold_r;
    reg                hold_v_r;
    reg [`WORD_W:0]    pipe_r [0:`PIPE_DEPTH-1];
    reg                pipe_v_r [0:`PIPE_DEPTH-1];
    reg [`WORD_W:0]    clip;
    integer            i;

    // Offset binary is two's complement with the top bit inverted.
    function [`WORD_W-1:0] to_gray;
        input [`WORD_W-1:0] tc;
        reg   [`WORD_W-1:0] ob;
        begin
            ob      = {~tc[`WORD_MSB], tc[`WORD_MSB-1:0]};
            to_gray = ob ^ (ob >> 1); // RQ13
        end
    endfunction

    // ****************************************************************
    // Quantizer clipping
    // ****************************************************************
    always @* begin
        if (analog_in > `FS_POS) begin
            clip = {1'b1, `CLIP_POS}; // RQ1
        end else if (analog_in < `FS_NEG) begin
            clip = {1'b1, `CLIP_NEG}; // RQ1
        end else begin
            clip = {1'b0, analog_in[`WORD_W-1:0]}; // RQ1
        end
    end

    // ****************************************************************
    // Pipeline: eight rising edges plus the half cycle of sampling
    // ****************************************************************
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r   <= {(`WORD_W+1){1'b0}};
            hold_v_r <= 1'b0;
            word_out <= {`WORD_W{1'b0}};
            oor_out  <= 1'b0;
            word_evt <= 1'b0;
            for (i = 0; i < `PIPE_DEPTH; i = i + 1) begin
                pipe_r[i]   <= {(`WORD_W+1){1'b0}};
                pipe_v_r[i] <= 1'b0;
            end
        end else if (flush) begin
            hold_v_r <= 1'b0;
            word_evt <= 1'b0;
            for (i = 0; i < `PIPE_DEPTH; i = i + 1) begin
                pipe_v_r[i] <= 1'b0;
            end
        end else begin
            word_evt <= 1'b0;
            if (take) begin
                hold_r   <= clip;  // RQ11
                hold_v_r <= 1'b1;
            end
            if (shift) begin
                pipe_r[0]   <= hold_r;    // RQ10
                pipe_v_r[0] <= hold_v_r;
                for (i = 1; i < `PIPE_DEPTH; i = i + 1) begin
                    pipe_r[i]   <= pipe_r[i-1];
                    pipe_v_r[i] <= pipe_v_r[i-1];
                end
                if (pipe_v_r[`PIPE_DEPTH-1]) begin
                    word_out <= gray_sel ? to_gray(pipe_r[`PIPE_DEPTH-1][`WORD_W-1:0])
                                         : pipe_r[`PIPE_DEPTH-1][`WORD_W-1:0]; // RQ6 RQ7 RQ2
                    oor_out  <= pipe_r[`PIPE_DEPTH-1][`WORD_W]; // RQ1
                    word_evt <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb/adc_out_core_sva.sv */
// Checker on the top ports of the ADC output interface.
// Assumes one hclk domain with hresetn active low; bound at the foot.
`timescale 1ns/10ps
`default_nettype none
module adc_out_core_sva #(
    parameter SETTLE_CYCLES = 20
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        conv_clk_p,
    input wire logic        power_down_input,
    input wire logic [11:0] sample_word_bus,
    input wire logic        out_of_range_flag,
    input wire logic        data_valid_clock,
    input wire logic        irq
);
    // ********
    // Properties
    // ********
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
    a_rdata_hold: assert property
        (!(hsel && hready && htrans == 2'h2 && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_pd_dv_low: assert property (power_down_input [*4] |-> !data_valid_clock)
        else $error("data valid clock runs in power down");
    a_pd_word_hold: assert property (power_down_input [*5] |->
        $stable(sample_word_bus) && $stable(out_of_range_flag))
        else $error("word changed in power down");
    a_oor_clipped: assert property (out_of_range_flag |->
        sample_word_bus inside {12'h7FF, 12'h800, 12'h000})
        else $error("flagged word is not a clipped value");
    // A slow pin sampler would let a rise slip past the three-edge window.
    a_dv_from_conv: assert property ($rose(data_valid_clock) |->
        $past(conv_clk_p, 1) || $past(conv_clk_p, 2) || $past(conv_clk_p, 3))
        else $error("data valid rose without a clock rise");
    a_flag_on_rise: assert property ($changed(out_of_range_flag) |->
        $past(conv_clk_p, 1) || $past(conv_clk_p, 2) || $past(conv_clk_p, 4))
        else $error("flag changed away from a clock rise");

    c_oor: cover property ($rose(out_of_range_flag));
    c_irq: cover property ($rose(irq));
    c_dv: cover property ($rose(data_valid_clock));
endmodule

bind adc_out_core adc_out_core_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.hclk, .hresetn,
    .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .conv_clk_p,
    .power_down_input, .sample_word_bus, .out_of_range_flag, .data_valid_clock, .irq);
`default_nettype wire

/* File: tb/adc_capture.sv */
// Back-end capture logic that latches each word and flag.
// Assumes word and flag are stable when the data valid clock falls.
`timescale 1ns/10ps
`default_nettype none
module adc_capture (
    input wire logic        hclk,
    input wire logic        data_valid_clock,
    input wire logic [11:0] word_in,
    input wire logic        oor_in,
    output logic     [11:0] cap_word,
    output logic            cap_oor
);
    // ********
    // Capture
    // ********
    logic dv_q = 1'b0;

    // Latching on the falling half avoids a race with the word update.
    always @(posedge hclk) begin
        dv_q <= data_valid_clock;
        if (dv_q && !data_valid_clock) begin
            cap_word <= word_in;
            cap_oor <= oor_in;
        end
    end
endmodule
`default_nettype wire

/* File: tb/adc_output_interface_tb.sv */
// Self-checking bench for the ADC output interface.
// Assumes the design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_output_interface_tb;
    // ********
    // Stimulus and checks
    // ********
    localparam int SETTLE = 20;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = 32'h0;
    logic               conv_clk_p = 1'b0;
    logic               conv_clk_n = 1'b1;
    logic signed [13:0] analog_sample = 14'h0;
    logic               power_down_input = 1'b0;
    wire  [31:0]        hrdata;
    wire                hreadyout;
    wire                hresp;
    wire  [11:0]        sample_word_bus;
    wire                out_of_range_flag;
    wire                data_valid_clock;
    wire                irq;
    wire  [11:0]        cap_word;
    wire                cap_oor;
    logic               conv_run = 1'b0;
    logic               n_stuck = 1'b0;
    int                 hi_len = 4;
    int                 lo_len = 4;
    int                 ph = 0;
    int                 cyc = 0;
    int                 n = 0;
    int                 error_cnt = 0;
    int                 samples_checked = 0;
    logic [31:0]        rd;
    int                 vals[8] = '{0, 1, -1, 2047, -2048, 2048, -2049, 341};

    adc_out_core #(.SETTLE_CYCLES(SETTLE)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .conv_clk_p, .conv_clk_n, .analog_sample, .power_down_input, .sample_word_bus,
        .out_of_range_flag, .data_valid_clock, .irq);
    adc_capture cap (.hclk, .data_valid_clock, .word_in(sample_word_bus),
        .oor_in(out_of_range_flag), .cap_word, .cap_oor);

    initial forever #2 hclk = ~hclk;

    // Conversion clock with adjustable high and low phases.
    always @(posedge hclk) begin
        ph <= (ph + 1 >= hi_len + lo_len) ? 0 : ph + 1;
        conv_clk_p <= conv_run && (ph < hi_len);
        conv_clk_n <= n_stuck || !(conv_run && (ph < hi_len));
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [12:0] expect_of(input int v, input bit gray);
        logic [11:0] w;
        logic [11:0] ob;
        w = (v > 2047) ? 12'h7FF : (v < -2048) ? 12'h800 : v[11:0];
        ob = w ^ 12'h800;
        if (gray) w = ob ^ (ob >> 1);
        return {(v > 2047 || v < -2048), w};
    endfunction

    task automatic settle_chk(input int v, input bit gray);
        logic [12:0] e;
        repeat (100) @(posedge hclk);
        e = expect_of(v, gray);
        chk(sample_word_bus, e[11:0]);
        chk(out_of_range_flag, e[12]);
        chk(cap_word, e[11:0]);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd[12:0], e);
    endtask

    task automatic meas(output int cnt);
        cnt = 0;
        do @(posedge hclk); while (data_valid_clock !== 1'b0);
        do @(posedge hclk); while (data_valid_clock !== 1'b1);
        do begin
            @(posedge hclk);
            cnt++;
        end while (data_valid_clock === 1'b1);
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h4);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 8'h0C, 32'h0000_0FFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd[12:0], 13'h0);
        end_test("registers");
        repeat (SETTLE) @(posedge hclk);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd[2], 1'b1);
        conv_run <= 1'b1;
        for (int g = 0; g < 2; g++) begin
            bus(1'b1, 8'h00, 32'h4 | g);
            foreach (vals[i]) begin
                analog_sample <= vals[i][13:0];
                settle_chk(vals[i], g[0]);
            end
        end
        end_test("formats");
        bus(1'b1, 8'h00, 32'h4);
        analog_sample <= 14'h64;
        settle_chk(100, 1'b0);
        do @(posedge hclk); while (ph != hi_len);
        analog_sample <= 14'h3F9C;
        for (int r = 1; r <= 9; r++) begin
            do @(posedge hclk); while (ph != 0);
            repeat (6) @(posedge hclk);
            chk(sample_word_bus, (r < 9) ? 12'h064 : 12'hF9C);
        end
        end_test("latency");
        hi_len <= 2;
        lo_len <= 6;
        repeat (40) @(posedge hclk);
        meas(n);
        chk(n, 4);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h8);
        bus(1'b1, 8'h00, 32'h0);
        repeat (40) @(posedge hclk);
        meas(n);
        chk(n, 2);
        hi_len <= 4;
        lo_len <= 4;
        bus(1'b1, 8'h00, 32'h4);
        end_test("duty");
        n_stuck <= 1'b1;
        analog_sample <= 14'h37;
        settle_chk(55, 1'b0);
        bus(1'b1, 8'h00, 32'h6);
        analog_sample <= 14'h42;
        settle_chk(55, 1'b0);
        n_stuck <= 1'b0;
        settle_chk(66, 1'b0);
        bus(1'b1, 8'h00, 32'h4);
        end_test("clock type");
        for (int k = 0; k < 2; k++) begin
            if (k == 0) power_down_input <= 1'b1;
            else bus(1'b1, 8'h00, 32'hC);
            analog_sample <= 14'(77 + k);
            repeat (20) @(posedge hclk);
            chk(data_valid_clock, 1'b0);
            settle_chk((k == 0) ? 66 : 77, 1'b0);
            power_down_input <= 1'b0;
            bus(1'b1, 8'h00, 32'h4);
            repeat (SETTLE) @(posedge hclk);
            settle_chk(77 + k, 1'b0);
        end
        end_test("power down");
        bus(1'b1, 8'h08, 32'h1);
        repeat (20) @(posedge hclk);
        chk(irq, 1'b1);
        power_down_input <= 1'b1;
        repeat (20) @(posedge hclk);
        bus(1'b1, 8'h04, 32'h7);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd[1:0], 2'h0);
        chk(irq, 1'b0);
        bus(1'b1, 8'h08, 32'h0);
        power_down_input <= 1'b0;
        repeat (SETTLE + 100) @(posedge hclk);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd[2:0], 3'h5);
        chk(irq, 1'b0);
        end_test("interrupt");
        complete_run();
    end
endmodule
`default_nettype wire
